// ==== rtl/dsg_params.svh ====
/*
  Constants of the deep-sleep gating and software-reset block: offsets,
  field positions, masks and reset values.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
// Function
// - A set gating bit clocks its unit; a clear bit leaves it unclocked.
// - Any access to a unit whose clock is off raises a bus fault.
// - All gating bits reset to 0, so every unit starts unclocked.
// - Separate run, sleep and deep-sleep gating registers; the current state's applies.
// - Sleep and deep-sleep gating apply only while automatic gating is selected.
// - Deep-sleep gating bits 7:0 clock ports H..A; bits 31:8 read zero.
// - Soft reset writes are masked bit by bit by the capability mask.
// - Soft reset bit 24 drives the CAN unit reset.
// - Soft reset bit 16 drives the converter module reset.
// - Soft reset bit 6 drives the low-power block reset.
// - Soft reset bit 3 drives the watchdog reset.
// - Soft reset resets to zero; its reserved bits read zero.
`ifndef DSG_PARAMS_SVH
`define DSG_PARAMS_SVH

`define DSG_AW            12
`define DSG_OFF_SRST      12'h040
`define DSG_OFF_CLKCFG    12'h060
`define DSG_OFF_RUN_GATE  12'h108
`define DSG_OFF_SLP_GATE  12'h118
`define DSG_OFF_DSL_GATE  12'h128
`define DSG_OFF_INT_STAT  12'h150
`define DSG_OFF_INT_EN    12'h154
`define DSG_OFF_INT_CLR   12'h158
`define DSG_OFF_ACTIVE    12'h160
`define DSG_OFF_FAULT_LOG 12'h164

`define DSG_GATE_RST      8'h00
`define DSG_SRST_RST      32'h0000_0000
`define DSG_SRST_WMASK    32'h0101_0048
`define DSG_BIT_CAN       24
`define DSG_BIT_ADC       16
`define DSG_BIT_LPB       6
`define DSG_BIT_WDOG      3
`define DSG_BIT_AUTO      27
`define DSG_INT_FAULT     0
`define DSG_INT_MASKED    1

`endif

// ==== rtl/dsg_pkg.sv ====
/*
  Types shared by the deep-sleep gating and software-reset block.
  Assumes the constants header is compiled alongside.
*/
package dsg_pkg;

  typedef enum logic [1:0] {
    DSG_MODE_RUN   = 2'b00,
    DSG_MODE_SLEEP = 2'b01,
    DSG_MODE_DEEP  = 2'b10
  } dsg_mode_type;

  typedef enum logic [3:0] {
    DSG_SEL_NONE   = 4'h0,
    DSG_SEL_SRST   = 4'h1,
    DSG_SEL_CLKCFG = 4'h2,
    DSG_SEL_RUN    = 4'h3,
    DSG_SEL_SLP    = 4'h4,
    DSG_SEL_DSL    = 4'h5,
    DSG_SEL_ISTAT  = 4'h6,
    DSG_SEL_IEN    = 4'h7,
    DSG_SEL_ICLR   = 4'h8,
    DSG_SEL_ACTIVE = 4'h9,
    DSG_SEL_FLOG   = 4'ha
  } dsg_sel_type;

endpackage

// ==== rtl/dsg_clk_gate.sv ====
/*
  Glitch-free clock gate for one unit.
  Assumes en changes only just after a rising edge of clk.
*/
`timescale 1ns/100ps
module dsg_clk_gate (
  input  wire logic sys_clk,  // Free-running clock
  input  wire logic nrst,     // Async reset, active low
  input  wire logic en,       // Gate enable
  output logic      gclk      // Gated clock
);

  // The enable is taken on the falling edge so it never changes while
  // the clock is high; that keeps runt pulses off the gated clock.
  logic en_low_reg;

  always_ff @(negedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_low_reg <= 1'b0;
    end else begin
      en_low_reg <= en;
    end
  end

  assign gclk = sys_clk & en_low_reg;

endmodule

// ==== rtl/dsg_apb_if.sv ====
/*
  APB handshake for the gating block: zero wait states, error on
  unmapped addresses, write and read-setup strobes.
  Assumes an APB3 master on sys_clk.
*/
`timescale 1ns/100ps
module dsg_apb_if (
  input  wire logic psel,      // Slave select
  input  wire logic penable,   // Access phase
  input  wire logic pwrite,    // Write when high
  input  wire logic addr_hit,  // Address is mapped
  output logic      wr_stb,    // Write takes effect this edge
  output logic      rd_setup,  // Read setup cycle
  output logic      pready,    // Transfer done
  output logic      pslverr    // Unmapped access
);

  // Every access completes in its first access cycle.
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~addr_hit;
  assign wr_stb   = psel & penable & pwrite & addr_hit;
  assign rd_setup = psel & ~penable & ~pwrite;

endmodule

// ==== rtl/dsg_top.sv ====
/*
  Deep-sleep clock gating and software reset control for eight ports
  and four peripheral units, with an APB register file and one
  level interrupt.
  Assumes power_mode, port_access and cap_mask_1 come from logic on
  sys_clk, and that the units treat their reset lines as active high.
*/
`timescale 1ns/100ps
`include "dsg_params.svh"
module dsg_top #(
  parameter int PORTS = 8
) (
  input  wire logic               sys_clk,               // System clock
  input  wire logic               nrst,                  // Async reset, low
  input  wire logic [11:0]        paddr,                 // APB address
  input  wire logic               psel,                  // APB select
  input  wire logic               penable,               // APB enable
  input  wire logic               pwrite,                // APB direction
  input  wire logic [31:0]        pwdata,                // APB write data
  output logic      [31:0]        prdata,                // APB read data
  output logic                    pready,                // APB ready
  output logic                    pslverr,               // APB error
  input  wire logic [1:0]         power_mode,            // Operating state
  input  wire logic [31:0]        cap_mask_1,            // Present units
  input  wire logic [PORTS-1:0]   port_access,           // Port access strobes
  output logic      [PORTS-1:0]   port_clk,              // Gated port clocks
  output logic      [PORTS-1:0]   port_clk_en,           // Port clock enabled
  output logic      [PORTS-1:0]   port_bus_fault,        // Fault per port
  output logic                    can_unit_reset,        // CAN reset
  output logic                    adc_unit_reset,        // Converter reset
  output logic                    low_power_block_reset, // Low-power reset
  output logic                    watchdog_unit_reset,   // Watchdog reset
  output logic                    irq                    // Interrupt level
);

  typedef struct packed {
    logic [PORTS-1:0] run_port_clock_gate;
    logic [PORTS-1:0] sleep_port_clock_gate;
    logic [PORTS-1:0] deep_sleep_port_clock_gate;
    logic             auto_gating_select;
    logic [31:0]      periph_soft_reset_0;
    logic [1:0]       int_status;
    logic [1:0]       int_enable;
    logic [PORTS-1:0] gate_en;
    logic [PORTS-1:0] fault;
    logic [PORTS-1:0] fault_log;
    logic [31:0]      rdata;
    logic             irq;
  } dsg_state_type;

  dsg_state_type      state_reg;
  dsg_state_type      state_next;
  dsg_pkg::dsg_sel_type sel;
  logic               addr_hit;
  logic               wr_stb;
  logic               rd_setup;
  logic [PORTS-1:0]   gate_sel;
  logic [PORTS-1:0]   fault_now;
  logic [31:0]        srst_wr;
  logic [31:0]        srst_allow;
  logic               masked_evt;

  // Address decode, shared by the read path and the write path.
  function automatic dsg_pkg::dsg_sel_type decode(input logic [11:0] a);
    dsg_pkg::dsg_sel_type s;
    s = dsg_pkg::DSG_SEL_NONE;
    unique case (a)
      `DSG_OFF_SRST:      s = dsg_pkg::DSG_SEL_SRST;
      `DSG_OFF_CLKCFG:    s = dsg_pkg::DSG_SEL_CLKCFG;
      `DSG_OFF_RUN_GATE:  s = dsg_pkg::DSG_SEL_RUN;
      `DSG_OFF_SLP_GATE:  s = dsg_pkg::DSG_SEL_SLP;
      `DSG_OFF_DSL_GATE:  s = dsg_pkg::DSG_SEL_DSL;
      `DSG_OFF_INT_STAT:  s = dsg_pkg::DSG_SEL_ISTAT;
      `DSG_OFF_INT_EN:    s = dsg_pkg::DSG_SEL_IEN;
      `DSG_OFF_INT_CLR:   s = dsg_pkg::DSG_SEL_ICLR;
      `DSG_OFF_ACTIVE:    s = dsg_pkg::DSG_SEL_ACTIVE;
      `DSG_OFF_FAULT_LOG: s = dsg_pkg::DSG_SEL_FLOG;
      default:            s = dsg_pkg::DSG_SEL_NONE;
    endcase
    return s;
  endfunction

  // Pads a port-wide field into a data word with zero upper bits.
  function automatic logic [31:0] widen(input logic [PORTS-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PORTS-1:0] = v;
    return w;
  endfunction

  assign sel      = decode(paddr);
  assign addr_hit = (sel != dsg_pkg::DSG_SEL_NONE);

  dsg_apb_if u_apb (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .addr_hit (addr_hit),
    .wr_stb   (wr_stb),
    .rd_setup (rd_setup),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  // Gating register that applies in the current operating state. An
  // unknown state code falls back to run gating, the safe choice since
  // software set that register for full operation.
  always_comb begin
    gate_sel = state_reg.run_port_clock_gate;
    if (state_reg.auto_gating_select) begin
      unique case (dsg_pkg::dsg_mode_type'(power_mode))
        dsg_pkg::DSG_MODE_RUN:   gate_sel = state_reg.run_port_clock_gate;
        dsg_pkg::DSG_MODE_SLEEP: gate_sel = state_reg.sleep_port_clock_gate;
        dsg_pkg::DSG_MODE_DEEP:  gate_sel = state_reg.deep_sleep_port_clock_gate;
        default:                 gate_sel = state_reg.run_port_clock_gate;
      endcase
    end
  end

  // An access to a port whose clock is off is refused.
  assign fault_now = port_access & ~state_reg.gate_en;

  // Soft reset write: only documented bits of present units may change.
  assign srst_allow = `DSG_SRST_WMASK & cap_mask_1;
  assign srst_wr    = (pwdata & srst_allow) |
                      (state_reg.periph_soft_reset_0 & ~srst_allow);
  assign masked_evt = wr_stb && (sel == dsg_pkg::DSG_SEL_SRST) &&
                      (((pwdata ^ state_reg.periph_soft_reset_0) &
                        `DSG_SRST_WMASK & ~cap_mask_1) != 32'h0000_0000);

  always_comb begin
    state_next = state_reg;

    state_next.gate_en   = gate_sel;
    state_next.fault     = fault_now;
    if (fault_now != '0) begin
      state_next.fault_log = fault_now;
    end

    if (wr_stb) begin
      unique case (sel)
        dsg_pkg::DSG_SEL_SRST:
          state_next.periph_soft_reset_0 = srst_wr;
        dsg_pkg::DSG_SEL_CLKCFG:
          state_next.auto_gating_select = pwdata[`DSG_BIT_AUTO];
        dsg_pkg::DSG_SEL_RUN:
          state_next.run_port_clock_gate = pwdata[PORTS-1:0];
        dsg_pkg::DSG_SEL_SLP:
          state_next.sleep_port_clock_gate = pwdata[PORTS-1:0];
        dsg_pkg::DSG_SEL_DSL:
          state_next.deep_sleep_port_clock_gate = pwdata[PORTS-1:0];
        dsg_pkg::DSG_SEL_IEN:
          state_next.int_enable = pwdata[1:0];
        dsg_pkg::DSG_SEL_ICLR:
          state_next.int_status = state_reg.int_status & ~pwdata[1:0];
        default: begin
        end
      endcase
    end

    // Events are applied after the clear so a new event is never lost.
    if (fault_now != '0) begin
      state_next.int_status[`DSG_INT_FAULT] = 1'b1;
    end
    if (masked_evt) begin
      state_next.int_status[`DSG_INT_MASKED] = 1'b1;
    end
    state_next.irq = |(state_next.int_status & state_next.int_enable);

    // Read data is captured in the setup cycle so it stands registered
    // through the zero-wait access cycle.
    if (rd_setup) begin
      unique case (sel)
        dsg_pkg::DSG_SEL_SRST:
          state_next.rdata = state_reg.periph_soft_reset_0 & `DSG_SRST_WMASK;
        dsg_pkg::DSG_SEL_CLKCFG: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rdata[`DSG_BIT_AUTO] = state_reg.auto_gating_select;
        end
        dsg_pkg::DSG_SEL_RUN:
          state_next.rdata = widen(state_reg.run_port_clock_gate);
        dsg_pkg::DSG_SEL_SLP:
          state_next.rdata = widen(state_reg.sleep_port_clock_gate);
        dsg_pkg::DSG_SEL_DSL:
          state_next.rdata = widen(state_reg.deep_sleep_port_clock_gate);
        dsg_pkg::DSG_SEL_ISTAT:
          state_next.rdata = {30'h0000_0000, state_reg.int_status};
        dsg_pkg::DSG_SEL_IEN:
          state_next.rdata = {30'h0000_0000, state_reg.int_enable};
        dsg_pkg::DSG_SEL_ACTIVE:
          state_next.rdata = widen(state_reg.gate_en);
        dsg_pkg::DSG_SEL_FLOG:
          state_next.rdata = widen(state_reg.fault_log);
        default:
          state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg.run_port_clock_gate        <= `DSG_GATE_RST;
      state_reg.sleep_port_clock_gate      <= `DSG_GATE_RST;
      state_reg.deep_sleep_port_clock_gate <= `DSG_GATE_RST;
      state_reg.auto_gating_select         <= 1'b0;
      state_reg.periph_soft_reset_0        <= `DSG_SRST_RST;
      state_reg.int_status                 <= 2'h0;
      state_reg.int_enable                 <= 2'h0;
      state_reg.gate_en                    <= `DSG_GATE_RST;
      state_reg.fault                      <= '0;
      state_reg.fault_log                  <= '0;
      state_reg.rdata                      <= 32'h0000_0000;
      state_reg.irq                        <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_gate
      dsg_clk_gate u_gate (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .en      (state_reg.gate_en[gi]),
        .gclk    (port_clk[gi])
      );
    end
  endgenerate

  assign port_clk_en    = state_reg.gate_en;
  assign port_bus_fault = state_reg.fault;
  assign prdata         = state_reg.rdata;
  assign irq            = state_reg.irq;

  // Reset lines follow the register directly; a set bit holds the unit.
  assign can_unit_reset        = state_reg.periph_soft_reset_0[`DSG_BIT_CAN];
  assign adc_unit_reset        = state_reg.periph_soft_reset_0[`DSG_BIT_ADC];
  assign low_power_block_reset = state_reg.periph_soft_reset_0[`DSG_BIT_LPB];
  assign watchdog_unit_reset   = state_reg.periph_soft_reset_0[`DSG_BIT_WDOG];

endmodule

// ==== tb/dsg_checker.sv ====
/*
  Assertions on the ports of dsg_top, bound to every instance.
  Assumes one clock domain and the zero-wait APB of the top.
*/
`timescale 1ns/100ps
module dsg_checker #(
  parameter int PORTS = 8
) (
  input wire logic             sys_clk,               // Clock
  input wire logic             nrst,                  // Reset, low
  input wire logic [11:0]      paddr,                 // Address
  input wire logic             psel,                  // Select
  input wire logic             penable,               // Access phase
  input wire logic             pwrite,                // Direction
  input wire logic [31:0]      pwdata,                // Write data
  input wire logic [31:0]      prdata,                // Read data
  input wire logic [31:0]      cap_mask_1,            // Present units
  input wire logic [PORTS-1:0] port_access,           // Port strobes
  input wire logic [PORTS-1:0] port_clk_en,           // Clock enables
  input wire logic [PORTS-1:0] port_bus_fault,        // Port faults
  input wire logic             can_unit_reset,        // CAN reset
  input wire logic             adc_unit_reset,        // Converter reset
  input wire logic             low_power_block_reset, // Low-power reset
  input wire logic             watchdog_unit_reset    // Watchdog reset
);
  logic        srst_wr;
  logic        rd_dsl;
  logic        rd_srst;
  logic [31:0] wok;
  assign srst_wr = psel & penable & pwrite & (paddr == 12'h040);
  assign rd_dsl  = psel & ~penable & ~pwrite & (paddr == 12'h128);
  assign rd_srst = psel & ~penable & ~pwrite & (paddr == 12'h040);
  assign wok     = cap_mask_1 & 32'h0101_0048;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_fault_flag: assert property (1'b1 |=> port_bus_fault == $past(port_access & ~port_clk_en))
    else $error("port fault flag wrong");
  chk_reset_idle: assert property ($rose(nrst) |-> port_clk_en == '0 && !can_unit_reset)
    else $error("outputs not idle after reset");
  chk_can_write: assert property (srst_wr && wok[24] |=> can_unit_reset == $past(pwdata[24]))
    else $error("can reset not written");
  chk_adc_write: assert property (srst_wr && wok[16] |=> adc_unit_reset == $past(pwdata[16]))
    else $error("converter reset not written");
  chk_lowpwr_write: assert property (srst_wr && wok[6] |=> low_power_block_reset == $past(pwdata[6]))
    else $error("low-power reset not written");
  chk_wdog_write: assert property (srst_wr && wok[3] |=> watchdog_unit_reset == $past(pwdata[3]))
    else $error("watchdog reset not written");
  chk_mask_block: assert property (srst_wr && !cap_mask_1[24] |=> $stable(can_unit_reset))
    else $error("absent unit reset changed");
  chk_reset_hold: assert property (!srst_wr |=> $stable(watchdog_unit_reset) && $stable(adc_unit_reset))
    else $error("reset line moved without write");
  chk_deep_rsvd: assert property (rd_dsl |=> prdata[31:8] == 24'h0)
    else $error("deep gate upper bits not zero");
  chk_srst_rsvd: assert property (rd_srst |=> (prdata & ~32'h0101_0048) == 32'h0)
    else $error("soft reset reserved bits not zero");
endmodule

bind dsg_top dsg_checker #(.PORTS(PORTS)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .cap_mask_1(cap_mask_1), .port_access(port_access),
  .port_clk_en(port_clk_en), .port_bus_fault(port_bus_fault), .can_unit_reset(can_unit_reset),
  .adc_unit_reset(adc_unit_reset), .low_power_block_reset(low_power_block_reset),
  .watchdog_unit_reset(watchdog_unit_reset)
);

// ==== tb/dsg_units.sv ====
/*
  Model of the ports behind the block: makes access strobes and counts
  rising edges of each gated port clock.
  Assumes the bench changes want just after a rising edge.
*/
`timescale 1ns/100ps
module dsg_units (
  input  wire logic       sys_clk,     // Clock
  input  wire logic       nrst,        // Reset, low
  input  wire logic [7:0] port_clk,    // Gated clocks
  input  wire logic [7:0] want,        // Accesses to make
  output logic      [7:0] port_access, // Access strobes
  output int              ticks [8]    // Clock edges seen
);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      port_access <= 8'h00;
    end else begin
      port_access <= want;
    end
  end
  // Counting edges, not levels, shows a clock that really runs.
  for (genvar i = 0; i < 8; i++) begin : g_port
    always @(posedge port_clk[i] or negedge nrst) begin
      if (!nrst) begin
        ticks[i] <= 0;
      end else begin
        ticks[i] <= ticks[i] + 1;
      end
    end
  end
endmodule

// ==== tb/test_deep_sleep_gating_and_sw_reset.sv ====
/*
  Self-checking bench for dsg_top against a register model.
  Assumes dsg_checker is bound to the design and dsg_units makes accesses.
*/
`timescale 1ns/100ps
`include "dsg_params.svh"
module test_deep_sleep_gating_and_sw_reset;
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, err, m_auto;
  logic        can_rst, adc_rst, lpb_rst, wdog_rst;
  logic [1:0]  power_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cap, rd, d, m_run, m_slp, m_dsl, m_srst, m_stat, m_ien, m_flog;
  logic [7:0]  port_clk, port_clk_en, port_bus_fault, port_access, want;
  logic [11:0] rst_addr [10] = '{12'h040, 12'h108, 12'h118, 12'h128, 12'h150,
                                 12'h060, 12'h154, 12'h158, 12'h160, 12'h164};
  int          err_count, n_checks, k, ticks [8], t0 [8];

  dsg_top #(.PORTS(8)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
    .cap_mask_1(cap), .port_access(port_access), .port_clk(port_clk), .port_clk_en(port_clk_en),
    .port_bus_fault(port_bus_fault), .can_unit_reset(can_rst), .adc_unit_reset(adc_rst),
    .low_power_block_reset(lpb_rst), .watchdog_unit_reset(wdog_rst), .irq(irq)
  );
  dsg_units u_units (.sys_clk(sys_clk), .nrst(nrst), .port_clk(port_clk), .want(want),
    .port_access(port_access), .ticks(ticks));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      err_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", rd, exp);
    chk("read error", err, 1'b0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    chk("write error", err, 1'b0);
    case (a)
      12'h040: begin
        if (|((wd ^ m_srst) & `DSG_SRST_WMASK & ~cap)) m_stat[1] = 1'b1;
        m_srst = (m_srst & ~(`DSG_SRST_WMASK & cap)) | (wd & `DSG_SRST_WMASK & cap);
      end
      12'h060: m_auto = wd[27];
      12'h108: m_run = wd & 32'hff;
      12'h118: m_slp = wd & 32'hff;
      12'h128: m_dsl = wd & 32'hff;
      12'h154: m_ien = wd & 32'h3;
      12'h158: m_stat = m_stat & ~wd;
      default: ;
    endcase
  endtask

  function automatic logic [7:0] exp_en();
    if (!m_auto || power_mode == 2'b00 || power_mode == 2'b11) return m_run[7:0];
    return (power_mode == 2'b01) ? m_slp[7:0] : m_dsl[7:0];
  endfunction

  task automatic check_state();
    logic [7:0] e;
    repeat (2) @(posedge sys_clk);
    #1;
    e = exp_en();
    chk("clock enable", port_clk_en, e);
    chk("reset lines", {can_rst, adc_rst, lpb_rst, wdog_rst}, {m_srst[24], m_srst[16], m_srst[6], m_srst[3]});
    chk("irq", irq, |(m_stat & m_ien));
    t0 = ticks;
    repeat (3) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 8; i++) chk("port clock", ticks[i] != t0[i], e[i]);
  endtask

  task automatic poke(input logic [7:0] v);
    logic [7:0] f;
    f = v & ~exp_en();
    @(posedge sys_clk);
    want <= v;
    @(posedge sys_clk);
    want <= 8'h00;
    @(posedge sys_clk);
    #1;
    chk("bus fault", port_bus_fault, f);
    if (|f) begin
      m_stat[0] = 1'b1;
      m_flog = f;
    end
  endtask

  initial begin
    {nrst, psel, penable, pwrite, m_auto} = '0;
    {paddr, pwdata, power_mode, want} = '0;
    {m_run, m_slp, m_dsl, m_srst, m_stat, m_ien, m_flog} = '0;
    cap = 32'hffff_ffff;
    err_count = 0;
    n_checks = 0;
    d = $urandom(32'hf77a859c);
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rst_addr[i]) rdc(rst_addr[i], 32'h0);
    apb(1'b0, 12'h7fc, 32'h0);
    chk("error flag", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    check_state();
    $display("test reset values done");
    wr(12'h154, 32'h3);
    // Every mode is tried with automatic gating off and on.
    for (k = 0; k < 8; k++) begin
      wr(12'h108, $urandom);
      wr(12'h118, $urandom);
      wr(12'h128, $urandom);
      wr(12'h060, (k > 3) ? 32'h0800_0000 : 32'h0);
      rdc(12'h060, {4'h0, m_auto, 27'h0});
      power_mode <= k[1:0];
      rdc(12'h118, m_slp);
      rdc(12'h128, m_dsl);
      check_state();
      poke(8'($urandom));
      rdc(12'h164, m_flog);
      rdc(12'h160, 32'(exp_en()));
      check_state();
      wr(12'h150, 32'hffff_ffff);
      wr(12'h154, (k == 7) ? 32'h0 : 32'h3);
      rdc(12'h154, m_ien);
      rdc(12'h150, m_stat);
      check_state();
      wr(12'h158, 32'h3);
      rdc(12'h150, m_stat);
    end
    $display("test gating and faults done");
    wr(12'h154, 32'h3);
    for (k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      cap <= (k < 2) ? 32'hffff_ffff : $urandom;
      rdc(12'h040, m_srst);
      d = (k == 0) ? 32'hffff_ffff : (rd & ~`DSG_SRST_WMASK) | ($urandom & `DSG_SRST_WMASK);
      wr(12'h040, (k == 1) ? 32'h0 : d);
      rdc(12'h040, m_srst);
      check_state();
    end
    $display("test soft reset done");
    close_out();
  end
endmodule
